/* File: rtl/wcs_defs.svh */
// Constants for the weld cycle sequencer: register map, fields, timing
//
// Overview of operation
// - Debounce setting off, 10, 20 or 30 ms filters foot and firing switches.
// - Air head: weld force starts within 1 ms plus debounce after foot level 1.
// - Firing switch must close within 10 s of force, else abort with timeout error.
// - Firing switch and foot level 2 closed: squeeze starts within 2 ms plus debounce.
// - Air head squeeze needs foot level 2 on, firing switch closed, soft touch finished.
// - Squeeze time programmable 0 to 999 ms in whole milliseconds.
// - Up-slope time programmable 0.0 to 99.0 ms in 0.1 ms steps.
// - Weld time programmable 0.0 to 99.0 ms in 0.1 ms steps.
// - Down-slope time programmable 0.0 to 99.0 ms in 0.1 ms steps.
// - Cool time programmable 0.0 to 99.0 ms in 0.1 ms steps.
// - Hold time programmable 0 to 999 ms in whole milliseconds.
// - Manual head: squeeze starts within 2 ms plus debounce after firing switch.
// - Remote firing: squeeze starts 23 ms, to within one 0.1 ms tick, after remote select turns on.
// - Mode setting selects air head, manual head or remote firing.
// - With soft touch, the 10 s timeout runs from foot level 2.
// - Converter calibration constants in writable registers are used directly as setpoint: high in weld, low in up- and down-slope.
// - Calibration steps: converter high, converter low, measure high, measure low, end.
// - Air valve driver energises as soon as foot level 1 is active.
// - Emergency stop open halts the cycle until the run key is pressed.
`ifndef WCS_DEFS_SVH
`define WCS_DEFS_SVH

`define WCS_A_CTRL 4'h0
`define WCS_A_SQZ 4'h1
`define WCS_A_UP 4'h2
`define WCS_A_WELD 4'h3
`define WCS_A_DOWN 4'h4
`define WCS_A_COOL 4'h5
`define WCS_A_HOLD 4'h6
`define WCS_A_SOFT 4'h7
`define WCS_A_STAT 4'h8
`define WCS_A_CAL 4'h9
`define WCS_A_CDH 4'ha
`define WCS_A_CDL 4'hb
`define WCS_A_CMH 4'hc
`define WCS_A_CML 4'hd

`define WCS_CTRL_RST 16'h0000
`define WCS_CTRL_MODE 1:0
`define WCS_CTRL_DEB 3:2
`define WCS_CTRL_SOFT 4
`define WCS_STAT_ST 3:0
`define WCS_STAT_ERR 4
`define WCS_STAT_HALT 5
`define WCS_STAT_CAL 8:6
`define WCS_CAL_START 0
`define WCS_CAL_NEXT 1
`define WCS_TIME_RST 10'h000
`define WCS_CAL_RST 12'h000

`define WCS_MODE_AIR 2'h0
`define WCS_MODE_MAN 2'h1
`define WCS_MODE_REM 2'h2

// Switch inputs in sync vector
`define WCS_SW_FOOT1 0
`define WCS_SW_FOOT2 1
`define WCS_SW_FIRE 2
`define WCS_SW_REM 3
`define WCS_SW_ESTOP 4
`define WCS_SW_RUN 5

`define WCS_CLK_NS 40
`define WCS_TICK_NS 100000
`define WCS_TICK_CYC ((`WCS_TICK_NS + `WCS_CLK_NS - 1) / `WCS_CLK_NS)
`define WCS_TICKS_PER_MS 4'h9
`define WCS_MS_TENTHS 14'h000a
`define WCS_DEB_10MS 9'h064
`define WCS_DEB_20MS 9'h0c8
`define WCS_DEB_30MS 9'h12c
`define WCS_REMOTE_MS 23
`define WCS_REMOTE_TENTHS 14'h00e6
`define WCS_FIRE_TMO_S 10
`define WCS_FIRE_TMO_MS 14'h2710

`endif

/* File: rtl/wcs_pkg.sv */
// Types for the weld cycle sequencer
package wcs_pkg;
`include "wcs_defs.svh"

    typedef enum logic [3:0] {
        ST_IDLE, ST_WAIT, ST_SOFT, ST_DELAY, ST_SQZ, ST_UP, ST_WELD,
        ST_DOWN, ST_COOL, ST_HOLD, ST_DONE, ST_HALT
    } wcs_st_t;

    typedef enum logic [2:0] {
        CAL_OFF, CAL_DAC_HI, CAL_DAC_LO, CAL_MEAS_HI, CAL_MEAS_LO, CAL_END
    } wcs_cal_t;

    typedef struct packed {
        logic [5:0] sync1;
        logic [5:0] sync2;
        logic run_prev;
        logic [2:0] deb_val;
        logic [2:0][8:0] deb_cnt;
        logic [11:0] presc;
        logic [3:0] dig;
        wcs_st_t st;
        logic [13:0] cnt;
        logic [13:0] tmo;
        logic soft_done;
        logic err;
        wcs_cal_t cal;
        logic [15:0] ctrl;
        logic [6:0][9:0] tp;
        logic [3:0][11:0] calk;
        logic [11:0] setp;
        logic [15:0] rdata;
    } wcs_state_t;
endpackage

/* File: rtl/wcs_top.sv */
// Weld cycle sequencer: switch inputs, phase timing, calibration store
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "wcs_defs.svh"
module wcs_top import wcs_pkg::*; #(
    parameter int TICK_CYC = `WCS_TICK_CYC
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic foot1_i,
    input wire logic foot2_i,
    input wire logic fire_i,
    input wire logic remote_sel_i,
    input wire logic estop_closed_i,
    input wire logic run_key_i,
    input wire logic [11:0] meas_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic weld_force_o,
    output logic air_valve_o,
    output logic weld_on_o,
    output logic [11:0] setpoint_o,
    output logic [3:0] phase_o,
    output logic fire_tmo_o,
    output logic halted_o
);
    wcs_state_t q, n;
    logic tick, ms_tick, run_edge, soft_en, in_wait;
    logic [1:0] mode;
    logic [8:0] deb_lim;
    logic [13:0] plen;
    logic [2:0] deb_raw;
    logic [2:0] deb_val_d;
    logic [2:0][8:0] deb_cnt_d;

    assign tick = (q.presc == 12'(TICK_CYC - 1));
    assign ms_tick = tick && (q.dig == `WCS_TICKS_PER_MS);
    assign run_edge = q.sync2[`WCS_SW_RUN] & ~q.run_prev;
    assign mode = q.ctrl[`WCS_CTRL_MODE];
    assign soft_en = q.ctrl[`WCS_CTRL_SOFT];
    assign in_wait = (q.st == ST_WAIT) || (q.st == ST_SOFT);
    assign deb_raw = {q.sync2[`WCS_SW_FIRE], q.sync2[`WCS_SW_FOOT2], q.sync2[`WCS_SW_FOOT1]};

    always_comb begin
        unique case (q.ctrl[`WCS_CTRL_DEB])
            2'h1: deb_lim = `WCS_DEB_10MS;
            2'h2: deb_lim = `WCS_DEB_20MS;
            2'h3: deb_lim = `WCS_DEB_30MS;
            default: deb_lim = 9'h000;
        endcase
    end

    for (genvar i = 0; i < 3; i++) begin : g_deb
        always_comb begin
            deb_val_d[i] = q.deb_val[i];
            deb_cnt_d[i] = 9'h000;
            if (deb_raw[i] != q.deb_val[i]) begin
                if (deb_lim == 9'h000) begin
                    deb_val_d[i] = deb_raw[i];
                end else if (tick) begin
                    deb_cnt_d[i] = q.deb_cnt[i] + 9'h001;
                    if (deb_cnt_d[i] >= deb_lim) begin
                        deb_val_d[i] = deb_raw[i];
                        deb_cnt_d[i] = 9'h000;
                    end
                end else begin
                    deb_cnt_d[i] = q.deb_cnt[i];
                end
            end
        end
    end

    // ms fields scaled to 0.1 ms; taken as is
    always_comb begin
        unique case (q.st)
            ST_SOFT: plen = 14'(q.tp[6] * `WCS_MS_TENTHS);
            ST_DELAY: plen = `WCS_REMOTE_TENTHS;
            ST_SQZ: plen = 14'(q.tp[0] * `WCS_MS_TENTHS);
            ST_UP: plen = {4'h0, q.tp[1]};
            ST_WELD: plen = {4'h0, q.tp[2]};
            ST_DOWN: plen = {4'h0, q.tp[3]};
            ST_COOL: plen = {4'h0, q.tp[4]};
            ST_HOLD: plen = 14'(q.tp[5] * `WCS_MS_TENTHS);
            default: plen = 14'h0000;
        endcase
    end

    always_comb begin
        n = q;
        n.sync1 = {run_key_i, estop_closed_i, remote_sel_i, fire_i, foot2_i, foot1_i};
        n.sync2 = q.sync1;
        n.run_prev = q.sync2[`WCS_SW_RUN];
        n.deb_val = deb_val_d;
        n.deb_cnt = deb_cnt_d;
        n.presc = tick ? 12'h000 : q.presc + 12'h001;
        if (tick) begin
            n.dig = ms_tick ? 4'h0 : q.dig + 4'h1;
            n.cnt = q.cnt + 14'h0001;
        end
        if (in_wait && ms_tick) begin
            n.tmo = q.tmo + 14'h0001;
        end

        unique case (q.st)
            ST_IDLE: begin
                n.soft_done = 1'b0;
                n.tmo = 14'h0000;
                n.cnt = 14'h0000;
                if (q.cal == CAL_OFF) begin
                    if (mode == `WCS_MODE_AIR && q.deb_val[`WCS_SW_FOOT1]) begin
                        // force and valve on at once
                        n.st = ST_WAIT;
                    end else if (mode == `WCS_MODE_MAN && q.deb_val[`WCS_SW_FIRE]) begin
                        n.st = ST_SQZ;
                    end else if (mode == `WCS_MODE_REM && q.sync2[`WCS_SW_REM]) begin
                        n.st = ST_DELAY;
                    end
                end
            end
            ST_WAIT: begin
                if (!q.deb_val[`WCS_SW_FOOT1]) begin
                    n.st = ST_DONE;
                end else if (q.deb_val[`WCS_SW_FOOT2] && q.deb_val[`WCS_SW_FIRE] && (q.soft_done || !soft_en)) begin
                    n.st = ST_SQZ;
                    n.cnt = 14'h0000;
                end else if (soft_en && !q.soft_done && q.deb_val[`WCS_SW_FOOT2]) begin
                    // timeout restarts at foot level 2
                    n.st = ST_SOFT;
                    n.cnt = 14'h0000;
                    n.tmo = 14'h0000;
                end
            end
            ST_SOFT: begin
                if (!q.deb_val[`WCS_SW_FOOT1] || !q.deb_val[`WCS_SW_FOOT2]) begin
                    n.st = q.deb_val[`WCS_SW_FOOT1] ? ST_WAIT : ST_DONE;
                end else if (q.cnt >= plen) begin
                    n.soft_done = 1'b1;
                    n.st = ST_WAIT;
                end
            end
            ST_DELAY: begin
                if (q.cnt >= plen) begin
                    n.st = ST_SQZ;
                    n.cnt = 14'h0000;
                end
            end
            // fixed phase order, zero length leaves after one cycle
            ST_SQZ, ST_UP, ST_WELD, ST_DOWN, ST_COOL, ST_HOLD: begin
                if (q.cnt >= plen) begin
                    n.cnt = 14'h0000;
                    n.st = (q.st == ST_HOLD) ? ST_DONE : wcs_st_t'(q.st + 4'h1);
                end
            end
            ST_DONE: begin
                // Raw and filtered levels both open, so one press gives one weld
                if (deb_raw == 3'h0 && q.deb_val == 3'h0 && !q.sync2[`WCS_SW_REM]) begin
                    n.st = ST_IDLE;
                end
            end
            ST_HALT: begin
                if (q.sync2[`WCS_SW_ESTOP] && run_edge) begin
                    n.st = ST_DONE;
                end
            end
        endcase

        // Register writes; error clear is ordered before the set below
        if (wr_i) begin
            unique case (addr_i)
                `WCS_A_CTRL: n.ctrl = wdata_i;
                `WCS_A_SQZ, `WCS_A_UP, `WCS_A_WELD, `WCS_A_DOWN, `WCS_A_COOL, `WCS_A_HOLD, `WCS_A_SOFT:
                    n.tp[addr_i - `WCS_A_SQZ] = wdata_i[9:0];
                `WCS_A_STAT: if (wdata_i[`WCS_STAT_ERR]) n.err = 1'b0;
                // calibration steps advance in fixed order
                `WCS_A_CAL: begin
                    if (wdata_i[`WCS_CAL_START] && q.cal == CAL_OFF && q.st == ST_IDLE) begin
                        n.cal = CAL_DAC_HI;
                    end else if (wdata_i[`WCS_CAL_NEXT] && q.cal != CAL_OFF) begin
                        if (q.cal == CAL_MEAS_HI) n.calk[2] = meas_i;
                        if (q.cal == CAL_MEAS_LO) n.calk[3] = meas_i;
                        n.cal = (q.cal == CAL_END) ? CAL_OFF : wcs_cal_t'(q.cal + 3'h1);
                    end
                end
                `WCS_A_CDH, `WCS_A_CDL, `WCS_A_CMH, `WCS_A_CML: n.calk[addr_i - `WCS_A_CDH] = wdata_i[11:0];
                default: ;
            endcase
        end

        // abort with sticky error on firing timeout
        if (in_wait && q.tmo >= `WCS_FIRE_TMO_MS) begin
            n.err = 1'b1;
            n.st = ST_DONE;
        end
        if (!q.sync2[`WCS_SW_ESTOP]) begin
            n.st = ST_HALT;
            n.cal = CAL_OFF;
        end

        unique case (q.st)
            ST_WELD: n.setp = q.calk[0];
            ST_UP, ST_DOWN: n.setp = q.calk[1];
            default: n.setp = (q.cal == CAL_DAC_HI) ? q.calk[0] : (q.cal == CAL_DAC_LO) ? q.calk[1] : 12'h000;
        endcase

        n.rdata = 16'h0000;
        if (rd_i) begin
            unique case (addr_i)
                `WCS_A_CTRL: n.rdata = q.ctrl;
                `WCS_A_SQZ, `WCS_A_UP, `WCS_A_WELD, `WCS_A_DOWN, `WCS_A_COOL, `WCS_A_HOLD, `WCS_A_SOFT:
                    n.rdata = {6'h00, q.tp[addr_i - `WCS_A_SQZ]};
                `WCS_A_STAT: begin
                    n.rdata[`WCS_STAT_ST] = q.st;
                    n.rdata[`WCS_STAT_ERR] = q.err;
                    n.rdata[`WCS_STAT_HALT] = (q.st == ST_HALT);
                    n.rdata[`WCS_STAT_CAL] = q.cal;
                end
                `WCS_A_CAL: n.rdata = {13'h0000, q.cal};
                `WCS_A_CDH, `WCS_A_CDL, `WCS_A_CMH, `WCS_A_CML: n.rdata = {4'h0, q.calk[addr_i - `WCS_A_CDH]};
                default: n.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.cal <= CAL_OFF;
            q.ctrl <= `WCS_CTRL_RST;
        end else begin
            q <= n;
        end
    end

    // force held from wait through hold except the remote delay, dropped after hold
    assign weld_force_o = (q.st >= ST_WAIT) && (q.st <= ST_HOLD) && (q.st != ST_DELAY);
    // valve follows force in air mode
    assign air_valve_o = weld_force_o && (mode == `WCS_MODE_AIR);
    assign weld_on_o = (q.st == ST_UP) || (q.st == ST_WELD) || (q.st == ST_DOWN);
    assign setpoint_o = q.setp;
    assign phase_o = q.st;
    assign fire_tmo_o = q.err;
    assign halted_o = (q.st == ST_HALT);
    assign rdata_o = q.rdata;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    estop_halt_a: assert property (!q.sync2[`WCS_SW_ESTOP] |=> q.st == ST_HALT)
        else $error("estop did not halt");
    halt_hold_a: assert property (q.st == ST_HALT && !run_edge |=> q.st == ST_HALT)
        else $error("halt left without run key");
    valve_foot_a: assert property (q.st == ST_IDLE && q.cal == CAL_OFF && mode == `WCS_MODE_AIR
        && q.deb_val[`WCS_SW_FOOT1] && q.sync2[`WCS_SW_ESTOP] |=> air_valve_o && weld_force_o)
        else $error("valve not energised on foot level 1");
    squeeze_gate_a: assert property (q.st == ST_WAIT ##1 q.st == ST_SQZ |->
        $past(q.deb_val[`WCS_SW_FOOT2] && q.deb_val[`WCS_SW_FIRE] && (q.soft_done || !soft_en)))
        else $error("squeeze started without conditions");
    fire_tmo_a: assert property (in_wait && q.tmo >= `WCS_FIRE_TMO_MS && q.sync2[`WCS_SW_ESTOP]
        |=> q.err && q.st == ST_DONE)
        else $error("firing timeout not flagged");
    remote_delay_a: assert property (q.st == ST_DELAY ##1 q.st == ST_SQZ |->
        $past(q.cnt) >= `WCS_REMOTE_TENTHS)
        else $error("remote squeeze too early");
    phase_order_a: assert property (q.st == ST_UP |=> q.st inside {ST_UP, ST_WELD, ST_HALT})
        else $error("up slope left out of order");
    hold_release_a: assert property (q.st == ST_HOLD ##1 q.st == ST_DONE |-> !weld_force_o)
        else $error("force kept after hold");
    deb_off_a: assert property (q.ctrl[`WCS_CTRL_DEB] == 2'h0 && $stable(q.ctrl)
        |=> q.deb_val == $past(deb_raw))
        else $error("switch not passed through with debounce off");
    cal_order_a: assert property (q.cal == CAL_DAC_LO |=> q.cal inside {CAL_DAC_LO, CAL_MEAS_HI, CAL_OFF})
        else $error("calibration step out of order");
    manual_start_a: assert property (q.st == ST_IDLE && q.cal == CAL_OFF && mode == `WCS_MODE_MAN
        && q.deb_val[`WCS_SW_FIRE] && q.sync2[`WCS_SW_ESTOP] |=> q.st == ST_SQZ)
        else $error("manual squeeze not started");
    done_release_a: assert property (q.st == ST_DONE && q.deb_val != 3'h0 && q.sync2[`WCS_SW_ESTOP]
        |=> q.st == ST_DONE)
        else $error("new cycle armed before switches released");
    squeeze_len_a: assert property (q.st == ST_SQZ && q.cnt < plen && q.sync2[`WCS_SW_ESTOP]
        |=> q.st == ST_SQZ)
        else $error("squeeze ended early");
    soft_restart_a: assert property (q.st == ST_WAIT ##1 q.st == ST_SOFT |-> q.tmo == 14'h0000)
        else $error("timeout not restarted at foot level 2");

    weld_seen_c: cover property (q.st == ST_WELD ##1 q.st == ST_DOWN);
    tmo_seen_c: cover property ($rose(q.err));
    remote_seen_c: cover property (q.st == ST_DELAY ##1 q.st == ST_SQZ);
    soft_seen_c: cover property (q.st == ST_SOFT ##1 q.soft_done);
    halt_seen_c: cover property (q.st == ST_HALT ##1 q.st == ST_DONE);
endmodule

/* File: test/wcs_switch_model.sv */
// Operator foot switch, weld head firing switch and remote select model
`timescale 1ns/10ps
`include "wcs_defs.svh"
module wcs_switch_model (
    input wire logic sys_clk_i,
    input wire logic go_i,
    input wire logic [1:0] mode_i,
    output logic foot1_o,
    output logic foot2_o,
    output logic fire_o,
    output logic remote_o
);
    logic [7:0] lag_q = 8'h00;
    initial {foot1_o, foot2_o, fire_o, remote_o} = 4'h0;
    // All switches open together when the operator lets go
    always @(posedge sys_clk_i) begin
        if (!go_i) begin
            lag_q <= 8'h00;
            {foot1_o, foot2_o, fire_o, remote_o} <= 4'h0;
        end else begin
            lag_q <= (lag_q == 8'hff) ? lag_q : lag_q + 8'h01;
            foot1_o <= (mode_i == `WCS_MODE_AIR);
            // Head builds force before level 2 and firing switch close
            foot2_o <= (mode_i == `WCS_MODE_AIR) && (lag_q >= 8'h14);
            fire_o <= (mode_i == `WCS_MODE_MAN) || ((mode_i == `WCS_MODE_AIR) && (lag_q >= 8'h14));
            remote_o <= (mode_i == `WCS_MODE_REM);
        end
    end
endmodule

/* File: test/weld_cycle_sequencer_bench.sv */
// Self-checking bench for the weld cycle sequencer
`timescale 1ns/10ps
module weld_cycle_sequencer_bench import wcs_pkg::*;;
    // Short tick keeps the run brief; one ms is ten ticks
    localparam int TC = 4;
    localparam int MS = 10 * TC;
    localparam logic [3:0] SEQ [5] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
    localparam logic [15:0] LIM [6] = '{16'h03e7, 16'h03de, 16'h03de, 16'h03de, 16'h03de, 16'h03e7};
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic estop_closed_i = 1'b1;
    logic run_key_i = 1'b0;
    logic go = 1'b0;
    logic [1:0] mode = 2'h1;
    logic [11:0] meas_i = 12'h000;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic foot1, foot2, fire, remote;
    logic weld_force_o, air_valve_o, weld_on_o, fire_tmo_o, halted_o;
    logic [15:0] rdata_o;
    logic [11:0] setpoint_o;
    logic [3:0] phase_o;
    logic [15:0] d;
    int fails = 0;
    int n_checks = 0;
    int n;
    int n1;

    always #20 sys_clk_i = ~sys_clk_i;

    wcs_switch_model sw (.sys_clk_i(sys_clk_i), .go_i(go), .mode_i(mode), .foot1_o(foot1), .foot2_o(foot2),
        .fire_o(fire), .remote_o(remote));
    wcs_top #(.TICK_CYC(TC)) uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .foot1_i(foot1), .foot2_i(foot2),
        .fire_i(fire), .remote_sel_i(remote), .estop_closed_i(estop_closed_i), .run_key_i(run_key_i),
        .meas_i(meas_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .weld_force_o(weld_force_o), .air_valve_o(air_valve_o), .weld_on_o(weld_on_o),
        .setpoint_o(setpoint_o), .phase_o(phase_o), .fire_tmo_o(fire_tmo_o), .halted_o(halted_o));

    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task chk_rng(input int v, input int lo, input int hi, input string msg);
        n_checks++;
        if (v < lo || v > hi) begin
            fails++;
            $display("CHECK FAILED at %0t: %s took %0d, allowed %0d to %0d", $time, msg, v, lo, hi);
        end
    endtask

    task wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    task rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask

    task wait_ph(input logic [3:0] ph, input int lim);
        #1;
        n = 0;
        while (phase_o !== ph) begin
            if (n >= lim) begin
                fails++;
                $display("CHECK FAILED at %0t: phase %0d not reached", $time, ph);
                wrap_up();
            end
            @(posedge sys_clk_i);
            #1 n++;
        end
    endtask

    task pulse_run;
        @(posedge sys_clk_i);
        run_key_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        run_key_i <= 1'b0;
        wait_ph(4'h0, 60);
    endtask

    // Follows one cycle from squeeze to done, watching weld on, force and the weld setpoint
    task trace;
        logic [3:0] last;
        int dur;
        logic [3:0] seen[$];
        last = phase_o;
        dur = 0;
        seen = {};
        for (int i = 0; i < 4000 && phase_o !== 4'ha; i++) begin
            @(posedge sys_clk_i);
            #1 dur++;
            if (phase_o !== last) begin
                if (dur > 1) seen.push_back(last);
                if (last === 4'h6) chk_rng(dur, 2 * TC, 4 * TC + 1, "weld phase");
                if (last === 4'h9) chk_rng(dur, 9 * TC, 11 * TC + 1, "hold phase");
                last = phase_o;
                dur = 0;
            end
            chk(weld_on_o, phase_o inside {4'h5, 4'h6, 4'h7}, "weld on");
            chk(weld_force_o, phase_o !== 4'ha, "force");
            if (phase_o === 4'h6 && dur > 0) chk(setpoint_o, 16'h0123, "weld setpoint");
        end
        chk(phase_o, 4'ha, "cycle end");
        chk(seen.size(), 5, "phase count");
        foreach (SEQ[j]) chk(seen[j], SEQ[j], "phase order");
    endtask

    initial begin
        repeat (5) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        pulse_run();
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0], d);
            chk(d, 16'h0000, "reset value");
        end
        $display("test reset done");
        for (int a = 0; a < 6; a++) begin
            wr(4'(a + 1), LIM[a]);
            rd(4'(a + 1), d);
            chk(d, LIM[a], "time limit");
        end
        wr(4'he, 16'hffff);
        rd(4'he, d);
        chk(d, 16'h0000, "unmapped");
        wr(4'h1, 16'h0001);
        wr(4'h2, 16'h0002);
        wr(4'h3, 16'h0003);
        wr(4'h4, 16'h0000);
        wr(4'h5, 16'h0001);
        wr(4'h6, 16'h0001);
        wr(4'ha, 16'h0123);
        wr(4'hb, 16'h0045);
        $display("test time fields done");
        // Manual head under every debounce choice
        for (int k = 0; k < 4; k++) begin
            wr(4'h0, 16'(4 * k + 1));
            go <= 1'b1;
            wait_ph(4'h4, k * 10 * MS + 2 * MS + 60);
            chk_rng(n, k * 10 * MS - TC, k * 10 * MS + 2 * MS + 1, "manual start");
            trace();
            go <= 1'b0;
            wait_ph(4'h0, 2000);
        end
        $display("test manual done");
        mode <= 2'h0;
        wr(4'h0, 16'h0000);
        go <= 1'b1;
        wait_ph(4'h1, MS + 2);
        chk_rng(n, 0, MS + 1, "force start");
        chk(air_valve_o, 1'b1, "air valve");
        n1 = n;
        wait_ph(4'h4, 2 * MS + 40);
        chk_rng(n1 + n, 21, 21 + 2 * MS + 1, "air squeeze");
        trace();
        go <= 1'b0;
        wait_ph(4'h0, 200);
        chk(air_valve_o, 1'b0, "valve off");
        $display("test air done");
        mode <= 2'h2;
        wr(4'h0, 16'h0002);
        go <= 1'b1;
        wait_ph(4'h4, 23 * MS + 40);
        chk_rng(n, 23 * MS - TC, 23 * MS + TC + 6, "remote delay");
        trace();
        go <= 1'b0;
        wait_ph(4'h0, 200);
        $display("test remote done");
        mode <= 2'h0;
        wr(4'h7, 16'h0001);
        wr(4'h0, 16'h0010);
        go <= 1'b1;
        wait_ph(4'h2, 2 * MS);
        chk(weld_force_o, 1'b1, "soft force");
        wait_ph(4'h4, 2 * MS);
        chk_rng(n, 9 * TC, 11 * TC + 3, "soft touch");
        trace();
        go <= 1'b0;
        wait_ph(4'h0, 200);
        $display("test soft done");
        mode <= 2'h1;
        wr(4'h0, 16'h0001);
        go <= 1'b1;
        wait_ph(4'h6, 200);
        estop_closed_i <= 1'b0;
        wait_ph(4'hb, 5);
        chk(weld_force_o, 1'b0, "halt force");
        chk(weld_on_o, 1'b0, "halt weld");
        go <= 1'b0;
        estop_closed_i <= 1'b1;
        repeat (30) @(posedge sys_clk_i);
        #1 chk(halted_o, 1'b1, "stays halted");
        pulse_run();
        $display("test stop done");
        wr(4'h9, 16'h0001);
        rd(4'h9, d);
        chk(d, 16'h0001, "cal step");
        chk(setpoint_o, 16'h0123, "dac high");
        wr(4'h9, 16'h0002);
        rd(4'h9, d);
        chk(d, 16'h0002, "cal step");
        chk(setpoint_o, 16'h0045, "dac low");
        meas_i <= 12'habc;
        wr(4'h9, 16'h0002);
        wr(4'h9, 16'h0002);
        rd(4'h9, d);
        chk(d, 16'h0004, "cal step");
        meas_i <= 12'h456;
        wr(4'h9, 16'h0002);
        rd(4'h9, d);
        chk(d, 16'h0005, "cal step");
        wr(4'h9, 16'h0002);
        rd(4'h9, d);
        chk(d, 16'h0000, "cal off");
        rd(4'hc, d);
        chk(d, 16'h0abc, "meas high");
        rd(4'hd, d);
        chk(d, 16'h0456, "meas low");
        chk(fire_tmo_o, 1'b0, "no timeout");
        $display("test calibration done");
        wrap_up();
    end
endmodule
